//--- design/lpir_mem.sv
// Small single-port-write, registered-read memory used for the display memories.
`timescale 1ns/10ps
module lpir_mem #(
  parameter int W  = 8,
  parameter int D  = 32,
  parameter int AW = 5
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [D];

  // Contents clear on reset so that refresh never puts unknown dots on the glass.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < D; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read data holds between reads so the consumer may sample it late.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else if (re)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : lpir_mem

//--- design/lpir_pkg.sv
// Shared constants, types and carriers for the LCD pattern, icon and cursor refresh block.
package lpir_pkg;

  localparam int          CLK_MHZ        = 250;
  localparam int          INIT_BUSY_MS   = 10;
  localparam int          RST_LOW_MIN_US = 1200;
  localparam int          INIT_BUSY_CYC  = INIT_BUSY_MS * 1000 * CLK_MHZ;
  localparam int          RST_LOW_CYC    = RST_LOW_MIN_US * CLK_MHZ;
  localparam int          CNT_W          = 22;

  localparam int          NUM_CHAR       = 14;
  localparam int          NUM_SEG        = 84;
  localparam int          NUM_COM        = 18;
  localparam int          CHAR_AW        = 5;
  localparam int          GLYPH_AW       = 6;
  localparam int          ICON_AW        = 4;

  localparam logic [6:0]  ICON_BASE      = 7'h60;
  localparam logic [6:0]  ICON_LAST      = 7'h6D;
  localparam logic [4:0]  LINE2_BASE     = 5'h10;
  localparam logic [4:0]  LINE_WRAP      = 5'h0F;
  localparam logic [3:0]  LAST_POS       = 4'hD;
  localparam logic [2:0]  LAST_COL       = 3'h5;
  localparam logic [2:0]  CURSOR_ROW     = 3'h7;
  localparam logic [4:0]  ROW_ICON_ONE   = 5'h10;
  localparam logic [4:0]  ROW_LAST       = 5'h11;
  localparam logic [6:0]  SHIFT_TOTAL    = 7'h54;
  localparam logic [5:0]  ALL_DOTS       = 6'h3F;
  localparam int          BLINK_W        = 5;

  typedef enum logic [1:0] {
    SEL_CHAR  = 2'h0,
    SEL_GLYPH = 2'h1,
    SEL_ICON  = 2'h2
  } lpir_sel_e;

  typedef enum logic [2:0] {
    ST_CODE  = 3'h0,
    ST_GLYPH = 3'h1,
    ST_LOAD  = 3'h3,
    ST_SHIFT = 3'h2,
    ST_LATCH = 3'h6
  } lpir_state_e;

  typedef struct packed {
    logic       en;
    lpir_sel_e  sel;
    logic [6:0] addr;
    logic [7:0] data;
  } lpir_hwr_s;

  typedef struct packed {
    logic       display_on;
    logic       cursor_on;
    logic       blink_on;
    logic [3:0] shift_one;
    logic [3:0] shift_two;
    logic [6:0] address_counter;
  } lpir_dctl_s;

  typedef struct packed {
    logic       busy_flag;
    logic [6:0] address_counter;
  } lpir_stat_s;

endpackage : lpir_pkg

//--- design/lpir_refresh.sv
// Display refresh: glyph lookup, icon map, cursor overlay, segment shift and busy timing.
`timescale 1ns/10ps
module lpir_refresh
  import lpir_pkg::*;
#(
  parameter int INIT_CYC = INIT_BUSY_CYC,
  parameter int RST_CYC  = RST_LOW_CYC
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         reset_pin_n,
  input  wire lpir_hwr_s    host_wr,
  input  wire lpir_dctl_s   disp_ctl,
  output logic              host_ready,
  output lpir_stat_s        status,
  output logic [NUM_COM-1:0] common_output,
  output logic [NUM_SEG-1:0] segment_output
);

  ////////////////////////////////////////////////////////////////////////////
  // Busy timing after power-up and after the reset pin.

  logic [CNT_W-1:0] rpin_cnt_r;
  logic [CNT_W-1:0] busy_cnt_r;
  logic             rpin_hit;
  logic             busy_live;

  // The pin must stay low strictly longer than the minimum before it counts.
  assign rpin_hit  = !reset_pin_n && (rpin_cnt_r == CNT_W'(RST_CYC));
  assign busy_live = rpin_hit || (busy_cnt_r != '0);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rpin_cnt_r <= '0;
    end
    else if (reset_pin_n)
    begin
      rpin_cnt_r <= '0;
    end
    else if (rpin_cnt_r != CNT_W'(RST_CYC))
    begin
      rpin_cnt_r <= rpin_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      busy_cnt_r <= CNT_W'(INIT_CYC);
    end
    else if (rpin_hit)
    begin
      busy_cnt_r <= CNT_W'(INIT_CYC);
    end
    else if (busy_cnt_r != '0)
    begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      status <= '{busy_flag: 1'b1, address_counter: 7'h00};
    end
    else
    begin
      status <= '{busy_flag: busy_live, address_counter: disp_ctl.address_counter};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host write slot.

  logic      ref_slot_r;
  lpir_hwr_s pend_r;
  logic      take;
  logic      wr_go;
  logic      char_we;
  logic      glyph_we;
  logic      icon_we;
  logic      icon_in_range;

  // Refresh owns every other cycle, so a host write can never tear a read.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ref_slot_r <= 1'b0;
    end
    else
    begin
      ref_slot_r <= !ref_slot_r;
    end
  end

  assign take          = host_wr.en && host_ready && !busy_live;
  assign wr_go         = pend_r.en && !ref_slot_r && !busy_live;
  assign icon_in_range = (pend_r.addr >= ICON_BASE) && (pend_r.addr <= ICON_LAST);
  assign char_we       = wr_go && (pend_r.sel == SEL_CHAR);
  assign glyph_we      = wr_go && (pend_r.sel == SEL_GLYPH);
  assign icon_we       = wr_go && (pend_r.sel == SEL_ICON) && icon_in_range;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend_r <= '0;
    end
    else if (busy_live)
    begin
      pend_r.en <= 1'b0;
    end
    else if (take)
    begin
      pend_r <= host_wr;
    end
    else if (wr_go)
    begin
      pend_r.en <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      host_ready <= 1'b0;
    end
    else
    begin
      host_ready <= !busy_live && !take && !(pend_r.en && !wr_go);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh sequencer.

  lpir_state_e         st_r;
  logic [3:0]          pos_r;
  logic [2:0]          col_r;
  logic [4:0]          row_r;
  logic [6:0]          shift_cnt_r;
  logic                glyph_user_r;
  logic [5:0]          pat_r;
  logic [5:0]          pat_nxt;
  logic [NUM_SEG-1:0]  sr_r;
  logic [BLINK_W-1:0]  blink_cnt_r;
  logic                latched_r;
  logic                icon_row;
  logic                line_two;
  logic [4:0]          pos_sum;
  logic [3:0]          pos_wrap;
  logic [4:0]          char_addr;
  logic                cursor_here;
  logic                latch_fire;
  logic                char_re;
  logic                glyph_re;
  logic                icon_re;
  logic [7:0]          char_rd;
  logic [5:0]          glyph_rd;
  logic [5:0]          icon_rd;

  assign icon_row = row_r >= ROW_ICON_ONE;
  assign line_two = row_r[3] && !icon_row;

  // Character positions follow the display shift; icons never do.
  assign pos_sum   = {1'b0, pos_r} + {1'b0, (line_two ? disp_ctl.shift_two
                                                      : disp_ctl.shift_one)};
  assign pos_wrap  = (pos_sum >= LINE_WRAP) ? 4'(pos_sum - LINE_WRAP) : pos_sum[3:0];
  assign char_addr = (line_two ? LINE2_BASE : 5'h00) | {1'b0, pos_wrap};

  // Upper counter bits are ignored, so a glyph address still places a cursor.
  assign cursor_here = char_addr == disp_ctl.address_counter[4:0];

  assign latch_fire = ref_slot_r && (st_r == ST_LATCH);
  assign char_re    = ref_slot_r && (st_r == ST_CODE) && !icon_row;
  assign icon_re    = ref_slot_r && (st_r == ST_CODE) && icon_row;
  assign glyph_re   = ref_slot_r && (st_r == ST_GLYPH) && !icon_row;

  lpir_mem #(.W(8), .D(32), .AW(CHAR_AW)) u_char_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .we      (char_we),
    .waddr   (pend_r.addr[CHAR_AW-1:0]),
    .wdata   (pend_r.data),
    .re      (char_re),
    .raddr   (char_addr),
    .rdata   (char_rd)
  );

  // Code bits 2..0 pick the glyph and row bits 2..0 the line inside it.
  lpir_mem #(.W(6), .D(64), .AW(GLYPH_AW)) u_glyph_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .we      (glyph_we),
    .waddr   (pend_r.addr[GLYPH_AW-1:0]),
    .wdata   (pend_r.data[5:0]),
    .re      (glyph_re),
    .raddr   ({char_rd[2:0], row_r[2:0]}),
    .rdata   (glyph_rd)
  );

  lpir_mem #(.W(6), .D(16), .AW(ICON_AW)) u_icon_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .we      (icon_we),
    .waddr   (ICON_AW'(pend_r.addr - ICON_BASE)),
    .wdata   (pend_r.data[5:0]),
    .re      (icon_re),
    .raddr   (pos_r),
    .rdata   (icon_rd)
  );

  // Fixed-font codes are outside this block and render blank here.
  always_comb
  begin
    pat_nxt = 6'h00;
    if (!busy_live && disp_ctl.display_on)
    begin
      if (icon_row)
      begin
        pat_nxt = icon_rd;
      end
      else
      begin
        pat_nxt = glyph_user_r ? glyph_rd : 6'h00;
        if (cursor_here && disp_ctl.blink_on && blink_cnt_r[BLINK_W-1])
        begin
          pat_nxt = ALL_DOTS;
        end
        if (cursor_here && disp_ctl.cursor_on && (row_r[2:0] == CURSOR_ROW))
        begin
          pat_nxt = pat_nxt | ALL_DOTS;
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r        <= ST_CODE;
      pos_r       <= 4'h0;
      col_r       <= 3'h0;
      row_r       <= 5'h00;
      shift_cnt_r <= 7'h00;
      glyph_user_r <= 1'b0;
      pat_r       <= 6'h00;
      sr_r        <= '0;
    end
    else if (ref_slot_r)
    begin
      case (st_r)
        ST_CODE:
        begin
          st_r <= ST_GLYPH;
        end
        ST_GLYPH:
        begin
          glyph_user_r <= char_rd[7:4] == 4'h0;
          st_r         <= ST_LOAD;
        end
        ST_LOAD:
        begin
          pat_r <= pat_nxt;
          col_r <= 3'h0;
          st_r  <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          sr_r        <= {pat_r[5], sr_r[NUM_SEG-1:1]};
          pat_r       <= {pat_r[4:0], 1'b0};
          shift_cnt_r <= shift_cnt_r + 1'b1;
          col_r       <= col_r + 1'b1;
          if (col_r == LAST_COL)
          begin
            if (pos_r == LAST_POS)
            begin
              st_r <= ST_LATCH;
            end
            else
            begin
              pos_r <= pos_r + 1'b1;
              st_r  <= ST_CODE;
            end
          end
        end
        ST_LATCH:
        begin
          pos_r       <= 4'h0;
          shift_cnt_r <= 7'h00;
          row_r       <= (row_r == ROW_LAST) ? 5'h00 : row_r + 1'b1;
          st_r        <= ST_CODE;
        end
        default:
        begin
          st_r <= ST_CODE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latch and common drivers.

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      segment_output <= '0;
    end
    else if (latch_fire && (shift_cnt_r == SHIFT_TOTAL))
    begin
      segment_output <= sr_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COM; gi++)
    begin : g_com
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          common_output[gi] <= 1'b0;
        end
        else if (latch_fire)
        begin
          common_output[gi] <= row_r == 5'(gi);
        end
      end
    end
  endgenerate

  // Blink phase advances once per full frame of all commons.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      blink_cnt_r <= '0;
      latched_r   <= 1'b0;
    end
    else if (latch_fire)
    begin
      latched_r <= 1'b1;
      if (row_r == ROW_LAST)
      begin
        blink_cnt_r <= blink_cnt_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_latch_after_84: assert property (@(posedge ref_clk) disable iff (!rst_n)
    latch_fire |-> shift_cnt_r == SHIFT_TOTAL)
    else $error("segment latch without 84 shifts");

  a_seg_hold_between: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !latch_fire |=> $stable(segment_output))
    else $error("segments changed outside latch");

  a_one_common_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    latched_r |-> $onehot(common_output))
    else $error("common select not one-hot");

  a_common_row_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
    latch_fire |=> common_output[$past(row_r)])
    else $error("wrong common selected");

  a_busy_blocks_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busy_live |-> !(char_we || glyph_we || icon_we))
    else $error("memory written while busy");

  a_slots_apart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (char_re || glyph_re || icon_re) |-> !(char_we || glyph_we || icon_we) && ref_slot_r)
    else $error("refresh read shares slot with host write");

  a_glyph_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ref_slot_r && st_r == ST_GLYPH) |=> glyph_user_r == (char_rd[7:4] == 4'h0))
    else $error("glyph select disagrees with code");

  a_cursor_row_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ref_slot_r && st_r == ST_LOAD && !icon_row && cursor_here && !busy_live &&
     disp_ctl.display_on && disp_ctl.cursor_on && row_r[2:0] == CURSOR_ROW)
    |=> pat_r == ALL_DOTS)
    else $error("cursor row not lit");

  a_rpin_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rpin_hit && reset_pin_n == 1'b0) |=> ##1 status.busy_flag [*8])
    else $error("busy dropped after reset pin");

  a_busy_reported: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busy_live |=> status.busy_flag)
    else $error("busy flag not reported");

endmodule : lpir_refresh

//--- testbench/lpir_host_model.sv
// Host processor model that writes the display memories through the write port.
`timescale 1ns/10ps
module lpir_host_model
  import lpir_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       host_ready,
  input  wire lpir_stat_s status,
  output lpir_hwr_s       host_wr
);
  int lost_count = 0;

  initial host_wr = '0;

  //////////////////////////////////////////////////////////////////////////////
  // Ready is sampled a half cycle early so the take edge never races its update.
  // A blind write skips the busy poll and gives up after four edges.
  task automatic wr(input lpir_sel_e sel, input logic [6:0] a, input logic [7:0] d,
                    input bit blind);
    int n;
    logic r;
    n = 0;
    r = 1'b0;
    while (!blind && status.busy_flag !== 1'b0 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    host_wr <= '{1'b1, sel, a, d};
    n = 0;
    do
    begin
      @(negedge ref_clk);
      r = host_ready;
      @(posedge ref_clk);
      n++;
    end
    while (r !== 1'b1 && n < (blind ? 4 : 200));
    host_wr <= '{1'b0, sel, ~a, ~d};
    // A polled write that never sees ready is a lost write, judged by the bench.
    if (!blind && r !== 1'b1)
    begin
      lost_count++;
    end
  endtask : wr

  task automatic icon_clear();
    for (int k = 0; k < NUM_CHAR; k++)
      wr(SEL_ICON, ICON_BASE + 7'(k), 8'h00, 1'b0);
  endtask : icon_clear
endmodule : lpir_host_model

//--- testbench/test_lpir_refresh.sv
// Self-checking testbench for the display refresh block.
`timescale 1ns/10ps
module test_lpir_refresh;
  import lpir_pkg::*;
  localparam int INIT    = 40;
  localparam int RSTC    = 10;
  localparam int ROW_CYC = (NUM_CHAR * 9 + 1) * 2;

  logic               ref_clk;
  logic               rst_n;
  logic               reset_pin_n;
  lpir_hwr_s          host_wr;
  lpir_dctl_s         ctl;
  logic               host_ready;
  lpir_stat_s         status;
  logic [NUM_COM-1:0] common_output;
  logic [NUM_SEG-1:0] segment_output;
  int                 bad_count   = 0;
  int                 check_count = 0;
  int                 cyc         = 0;
  int                 row_at [NUM_COM];

  lpir_refresh #(.INIT_CYC(INIT), .RST_CYC(RSTC)) lpir_refresh_inst (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .reset_pin_n    (reset_pin_n),
    .host_wr        (host_wr),
    .disp_ctl       (ctl),
    .host_ready     (host_ready),
    .status         (status),
    .common_output  (common_output),
    .segment_output (segment_output)
  );

  lpir_host_model lpir_host_model_inst (
    .ref_clk    (ref_clk),
    .host_ready (host_ready),
    .status     (status),
    .host_wr    (host_wr)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    cmp_cnt(lpir_host_model_inst.lost_count, 0, 0);
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic fail(input string m);
    bad_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  task automatic cmp_vec(input logic [NUM_SEG-1:0] g, input logic [NUM_SEG-1:0] e);
    check_count++;
    if (g !== e)
      fail($sformatf("vector got %h exp %h", g, e));
  endtask : cmp_vec

  task automatic cmp_dots(input logic [5:0] g, input logic [5:0] e);
    check_count++;
    if (g !== e)
      fail($sformatf("dots got %h exp %h", g, e));
  endtask : cmp_dots

  task automatic cmp_bit(input logic g, input logic e);
    check_count++;
    if (g !== e)
      fail($sformatf("flag got %b exp %b", g, e));
  endtask : cmp_bit

  task automatic cmp_cnt(input int g, input int lo, input int hi);
    check_count++;
    if (g < lo || g > hi)
      fail($sformatf("count %0d outside %0d..%0d", g, lo, hi));
  endtask : cmp_cnt

  //////////////////////////////////////////////////////////////////////////////
  // Glyph bits 7:6 are set on purpose; only bits 5:0 may reach the glass.
  function automatic logic [7:0] pat(int g, int r);
    return {2'b11, 6'((g * 7 + r * 5 + 3) % 64)};
  endfunction : pat

  function automatic logic [5:0] dots(logic [7:0] d);
    return {d[0], d[1], d[2], d[3], d[4], d[5]};
  endfunction : dots

  function automatic logic [5:0] slice(int k);
    return segment_output[6 * k +: 6];
  endfunction : slice

  // Waits for a fresh latch of common k; the one-hot match itself is checked.
  task automatic wait_row(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (common_output === NUM_COM'(1 << k) && n < 9200);
    while (common_output !== NUM_COM'(1 << k) && n < 9200)
    begin
      @(negedge ref_clk);
      n++;
    end
    row_at[k] = cyc;
    check_count++;
    if (n >= 9200)
      fail($sformatf("common %0d never selected", k));
  endtask : wait_row

  task automatic busy_len(output int n);
    n = 0;
    while (status.busy_flag === 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask : busy_len

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    int n;
    @(negedge ref_clk);
    cmp_bit(host_ready, 1'b0);
    busy_len(n);
    cmp_cnt(n, INIT - 1, INIT + 3);
    @(posedge ref_clk);
    ctl.address_counter <= 7'h5A;
    repeat (3) @(negedge ref_clk);
    cmp_vec(NUM_SEG'(status.address_counter), NUM_SEG'(7'h5A));
    cmp_bit(host_ready, 1'b1);
  endtask : t_power

  task automatic t_glyph();
    lpir_host_model_inst.icon_clear();
    for (int g = 0; g < 8; g += 7)
      for (int r = 0; r < 8; r++)
        lpir_host_model_inst.wr(SEL_GLYPH, 7'(g * 8 + r), pat(g, r), 1'b0);
    lpir_host_model_inst.wr(SEL_CHAR, 7'h00, 8'h08, 1'b0);
    lpir_host_model_inst.wr(SEL_CHAR, 7'h01, 8'h10, 1'b0);
    lpir_host_model_inst.wr(SEL_CHAR, 7'h02, 8'h07, 1'b0);
    lpir_host_model_inst.wr(SEL_CHAR, 7'h10, 8'h07, 1'b0);
    @(posedge ref_clk);
    ctl.display_on <= 1'b1;
    wait_row(17);
    for (int r = 0; r < 8; r++)
    begin
      wait_row(r);
      cmp_dots(slice(0), dots(pat(0, r)));
      cmp_dots(slice(1), 6'h00);
      cmp_dots(slice(2), dots(pat(7, r)));
    end
    cmp_cnt(row_at[1] - row_at[0], ROW_CYC, ROW_CYC);
  endtask : t_glyph

  task automatic t_cursor();
    @(posedge ref_clk);
    ctl.cursor_on       <= 1'b1;
    ctl.address_counter <= 7'h00;
    wait_row(17);
    wait_row(0);
    cmp_dots(slice(0), dots(pat(0, 0)));
    wait_row(7);
    cmp_dots(slice(0), 6'h3F);
    cmp_dots(slice(2), dots(pat(7, 7)));
    @(posedge ref_clk);
    ctl.address_counter <= 7'h42;
    wait_row(17);
    wait_row(7);
    cmp_dots(slice(2), 6'h3F);
    cmp_dots(slice(0), dots(pat(0, 7)));
    @(posedge ref_clk);
    ctl.cursor_on <= 1'b0;
  endtask : t_cursor

  task automatic t_icon();
    logic [NUM_SEG-1:0] e;
    for (int k = 0; k < NUM_CHAR; k++)
    begin
      lpir_host_model_inst.wr(SEL_ICON, ICON_BASE + 7'(k), {2'b10, 6'(k * 11 + 5)}, 1'b0);
      e[6 * k +: 6] = dots({2'b00, 6'(k * 11 + 5)});
    end
    wait_row(17);
    wait_row(0);
    cmp_dots(slice(0), dots(pat(0, 0)));
    wait_row(16);
    cmp_vec(segment_output, e);
    wait_row(17);
    cmp_vec(segment_output, e);
    @(posedge ref_clk);
    ctl.shift_one <= 4'h3;
    ctl.shift_two <= 4'h5;
    wait_row(17);
    wait_row(0);
    cmp_dots(slice(13), 6'h00);
    wait_row(16);
    cmp_vec(segment_output, e);
    @(posedge ref_clk);
    ctl.shift_one <= 4'h0;
    ctl.shift_two <= 4'h0;
  endtask : t_icon

  task automatic t_rstpin();
    int n;
    @(posedge ref_clk);
    reset_pin_n <= 1'b0;
    repeat (RSTC - 2) @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    repeat (4) @(negedge ref_clk);
    cmp_bit(status.busy_flag, 1'b0);
    @(posedge ref_clk);
    reset_pin_n <= 1'b0;
    repeat (RSTC + 4) @(posedge ref_clk);
    lpir_host_model_inst.wr(SEL_GLYPH, 7'h00, 8'h00, 1'b1);
    @(negedge ref_clk);
    cmp_bit(status.busy_flag, 1'b1);
    @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    busy_len(n);
    cmp_cnt(n, INIT - 1, INIT + 3);
    wait_row(17);
    wait_row(0);
    cmp_dots(slice(0), dots(pat(0, 0)));
  endtask : t_rstpin

  // The blink phase only turns after sixteen frames, so this waits frame by frame.
  task automatic t_blink();
    int f;
    @(posedge ref_clk);
    ctl.blink_on        <= 1'b1;
    ctl.address_counter <= 7'h00;
    wait_row(17);
    f = 0;
    do
    begin
      wait_row(0);
      f++;
    end
    while (slice(0) !== 6'h3F && f < 20);
    cmp_dots(slice(0), 6'h3F);
    cmp_dots(slice(2), dots(pat(7, 0)));
    wait_row(8);
    cmp_dots(slice(0), dots(pat(7, 0)));
  endtask : t_blink

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n       = 1'b0;
    reset_pin_n = 1'b1;
    ctl         = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_power();
    t_glyph();
    t_cursor();
    t_icon();
    t_rstpin();
    t_blink();
    test_done();
  end

  // Sized above the run, whose longest part waits out the first blink phase.
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    fail("watchdog expired");
    test_done();
  end
endmodule : test_lpir_refresh
